// ---- uart_pkg.sv ----
// Behaviour
// - full-duplex asynchronous port with 8-bit and 9-bit variable-rate frame modes.
// - one received byte is buffered while the next byte is being received.
// - writing the data buffer loads the transmit register and starts sending.
// - reading the data buffer returns the receive register; transmit data unreadable.
// - interrupt requested when transmit-done or receive-done flag sets, if enabled.
// - done flags stay set until software clears them.
// - transmit bit clock comes from baud timer low byte overflows, auto-reload.
// - hidden receive timer copies low byte counting, same reload value.
// - both timer overflow streams are divided by two for bit rate.
// - detected start edge forces receive timer reload.
// - baud timer clock selectable among six sources.
// - system clock may stay internal while external oscillator drives timer.
// - frame is start, eight data LSB first, optional ninth, stop.
// - transmit-done flag sets at the start of the stop bit.
// - receive stores only if flag clear and multiprocessor check passes.
// - receive needs enable bit; ninth or stop bit stored in ninth-bit field.
package uart_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam int CTL_FRAME_WIDTH = 7;
  localparam int CTL_UNUSED_ONE = 6;
  localparam int CTL_MPCE = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TX9 = 3;
  localparam int CTL_RX9 = 2;
  localparam int CTL_TDONE = 1;
  localparam int CTL_RDONE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [2:0] CLKSEL_SYS = 3'h0;
  localparam logic [2:0] CLKSEL_DIV4 = 3'h1;
  localparam logic [2:0] CLKSEL_DIV12 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV48 = 3'h3;
  localparam logic [2:0] CLKSEL_EXT8 = 3'h4;
  localparam logic [2:0] CLKSEL_PIN = 3'h5;
  localparam logic [5:0] PRESCALE_WRAP = 6'h2f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- baud_tick_gen.sv ----
module baud_tick_gen (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic ext_osc_sync,
  input wire logic ext_pin_sync,
  output logic tick
);
  typedef struct packed {
    logic [5:0] div48_ff;
    logic [2:0] osc_div_ff;
    logic osc_prev_ff;
    logic pin_prev_ff;
  } pre_s;
  pre_s st_ff;
  pre_s nxt_st;
  logic osc_rise;
  always_comb begin
    nxt_st = st_ff;
    osc_rise = ext_osc_sync & ~st_ff.osc_prev_ff;
    nxt_st.osc_prev_ff = ext_osc_sync;
    nxt_st.pin_prev_ff = ext_pin_sync;
    nxt_st.div48_ff = (st_ff.div48_ff == uart_pkg::PRESCALE_WRAP) ? 6'h00 : st_ff.div48_ff + 6'h01;
    if (osc_rise) begin
      nxt_st.osc_div_ff = st_ff.osc_div_ff + 3'h1;
    end
    tick = 1'b0;
    // six timer clock sources
    unique case (clk_sel)
      uart_pkg::CLKSEL_SYS: tick = 1'b1;
      uart_pkg::CLKSEL_DIV4: tick = (st_ff.div48_ff[1:0] == 2'h3);
      uart_pkg::CLKSEL_DIV12: tick = (st_ff.div48_ff % 6'd12 == 6'd11);
      uart_pkg::CLKSEL_DIV48: tick = (st_ff.div48_ff == uart_pkg::PRESCALE_WRAP);
      uart_pkg::CLKSEL_EXT8: tick = osc_rise && (st_ff.osc_div_ff == 3'h7);
      uart_pkg::CLKSEL_PIN: tick = ext_pin_sync & ~st_ff.pin_prev_ff;
      default: tick = 1'b0;
    endcase
    tick = tick & run;
  end
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- uart_serial_port.sv ----
module uart_serial_port (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RX_PIN,
  output logic TX_PIN,
  input wire logic EXT_OSC,
  input wire logic TIMER_EXT_PIN,
  output logic IRQ
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_STOP = 2'b10
  } tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_e;
  typedef struct packed {
    logic [1:0] rx_sync_ff;
    logic [1:0] osc_sync_ff;
    logic [1:0] pin_sync_ff;
    logic rx_prev_ff;
    logic aw_ff;
    logic [7:0] awaddr_ff;
    logic w_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] control_ff;
    logic [7:0] reload_ff;
    logic [2:0] clk_sel_ff;
    logic timer_run_ff;
    logic [7:0] tx_timer_ff;
    logic [7:0] rx_timer_ff;
    logic tx_half_ff;
    logic rx_half_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    tx_state_e tx_state_ff;
    logic [9:0] tx_shift_ff;
    logic [3:0] tx_count_ff;
    logic tx_pin_ff;
    rx_state_e rx_state_ff;
    logic [8:0] rx_shift_ff;
    logic [3:0] rx_count_ff;
    logic [7:0] rx_buffer_ff;
  } state_s;
  state_s st_ff;
  state_s nxt_st;
  logic tick;
  logic tx_ovf;
  logic rx_ovf;
  logic tx_bit;
  logic rx_mid;
  logic rx_in;
  logic wr_go;
  logic rd_go;
  logic set_tdone;
  logic set_rdone;
  logic rx_ok;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;

  baud_tick_gen u_tick (
    .CORE_CLK(CORE_CLK),
    .RESETN(RESETN),
    .run(st_ff.timer_run_ff),
    .clk_sel(st_ff.clk_sel_ff),
    .ext_osc_sync(st_ff.osc_sync_ff[1]),
    .ext_pin_sync(st_ff.pin_sync_ff[1]),
    .tick(tick)
  );

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction

  assign S_AXI_AWREADY = ~st_ff.aw_ff & ~st_ff.bvalid_ff;
  assign S_AXI_WREADY = ~st_ff.w_ff & ~st_ff.bvalid_ff;
  assign S_AXI_ARREADY = ~st_ff.rvalid_ff;
  assign S_AXI_BVALID = st_ff.bvalid_ff;
  assign S_AXI_BRESP = st_ff.bresp_ff;
  assign S_AXI_RVALID = st_ff.rvalid_ff;
  assign S_AXI_RDATA = st_ff.rdata_ff;
  assign S_AXI_RRESP = st_ff.rresp_ff;
  assign TX_PIN = st_ff.tx_pin_ff;
  assign IRQ = |(st_ff.irq_status_ff & st_ff.irq_mask_ff);

  always_comb begin
    nxt_st = st_ff;
    rd_val = 32'h0;
    rd_resp = uart_pkg::RESP_OKAY;
    set_tdone = 1'b0;
    set_rdone = 1'b0;
    rx_ok = 1'b0;
    // pins cross two flops before any use
    nxt_st.rx_sync_ff = {st_ff.rx_sync_ff[0], RX_PIN};
    nxt_st.osc_sync_ff = {st_ff.osc_sync_ff[0], EXT_OSC};
    nxt_st.pin_sync_ff = {st_ff.pin_sync_ff[0], TIMER_EXT_PIN};
    rx_in = st_ff.rx_sync_ff[1];
    nxt_st.rx_prev_ff = rx_in;

    // baud timers: 8-bit auto-reload
    tx_ovf = tick && (st_ff.tx_timer_ff == 8'hff);
    rx_ovf = tick && (st_ff.rx_timer_ff == 8'hff);
    if (tick) begin
      nxt_st.tx_timer_ff = tx_ovf ? st_ff.reload_ff : st_ff.tx_timer_ff + 8'h01;
      nxt_st.rx_timer_ff = rx_ovf ? st_ff.reload_ff : st_ff.rx_timer_ff + 8'h01;
    end
    if (tx_ovf) begin
      nxt_st.tx_half_ff = ~st_ff.tx_half_ff;
    end
    if (rx_ovf) begin
      nxt_st.rx_half_ff = ~st_ff.rx_half_ff;
    end
    tx_bit = tx_ovf & st_ff.tx_half_ff;
    rx_mid = rx_ovf & ~st_ff.rx_half_ff;

    // transmitter
    unique case (st_ff.tx_state_ff)
      TX_IDLE: nxt_st.tx_pin_ff = 1'b1;
      TX_SHIFT: begin
        if (tx_bit) begin
          nxt_st.tx_pin_ff = st_ff.tx_shift_ff[0];
          nxt_st.tx_shift_ff = {1'b1, st_ff.tx_shift_ff[9:1]};
          nxt_st.tx_count_ff = st_ff.tx_count_ff - 4'h1;
          if (st_ff.tx_count_ff == 4'h1) begin
            nxt_st.tx_state_ff = TX_STOP;
            set_tdone = 1'b1;
          end
        end
      end
      TX_STOP: begin
        if (tx_bit) begin
          nxt_st.tx_state_ff = TX_IDLE;
        end
      end
    endcase

    // receiver
    unique case (st_ff.rx_state_ff)
      RX_IDLE: begin
        if (st_ff.control_ff[uart_pkg::CTL_REN] && st_ff.rx_prev_ff && !rx_in) begin
          nxt_st.rx_state_ff = RX_START;
          nxt_st.rx_timer_ff = st_ff.reload_ff;
          nxt_st.rx_half_ff = 1'b0;
          nxt_st.rx_count_ff = st_ff.control_ff[uart_pkg::CTL_FRAME_WIDTH] ? 4'h9 : 4'h8;
        end
      end
      RX_START: begin
        if (rx_mid) begin
          nxt_st.rx_state_ff = rx_in ? RX_IDLE : RX_DATA; // false start rejected
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          nxt_st.rx_shift_ff = {rx_in, st_ff.rx_shift_ff[8:1]};
          nxt_st.rx_count_ff = st_ff.rx_count_ff - 4'h1;
          if (st_ff.rx_count_ff == 4'h1) begin
            nxt_st.rx_state_ff = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          nxt_st.rx_state_ff = RX_IDLE;
          // 9-bit frame keeps ninth bit, 8-bit keeps stop bit
          if (st_ff.control_ff[uart_pkg::CTL_FRAME_WIDTH]) begin
            rx_ok = ~st_ff.control_ff[uart_pkg::CTL_RDONE] &&
                    (~st_ff.control_ff[uart_pkg::CTL_MPCE] || st_ff.rx_shift_ff[8]);
            if (rx_ok) begin
              nxt_st.rx_buffer_ff = st_ff.rx_shift_ff[7:0];
              nxt_st.control_ff[uart_pkg::CTL_RX9] = st_ff.rx_shift_ff[8];
            end
          end else begin
            rx_ok = ~st_ff.control_ff[uart_pkg::CTL_RDONE] &&
                    (~st_ff.control_ff[uart_pkg::CTL_MPCE] || rx_in);
            if (rx_ok) begin
              nxt_st.rx_buffer_ff = st_ff.rx_shift_ff[8:1];
              nxt_st.control_ff[uart_pkg::CTL_RX9] = rx_in;
            end
          end
          set_rdone = rx_ok;
        end
      end
    endcase

    // axi write
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_st.aw_ff = 1'b1;
      nxt_st.awaddr_ff = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_st.w_ff = 1'b1;
      nxt_st.wdata_ff = S_AXI_WDATA;
      nxt_st.wstrb_ff = S_AXI_WSTRB;
    end
    wr_go = st_ff.aw_ff & st_ff.w_ff;
    if (wr_go) begin
      nxt_st.aw_ff = 1'b0;
      nxt_st.w_ff = 1'b0;
      nxt_st.bvalid_ff = 1'b1;
      nxt_st.bresp_ff = uart_pkg::RESP_OKAY;
      unique case ({st_ff.awaddr_ff[7:2], 2'b00})
        uart_pkg::ADDR_CONTROL: begin
          // flags writable, software alone clears them
          nxt_st.control_ff = merge_byte(st_ff.control_ff, st_ff.wdata_ff, st_ff.wstrb_ff) |
                              8'(1 << uart_pkg::CTL_UNUSED_ONE);
        end
        uart_pkg::ADDR_DATA: begin
          // a write while sending restarts with the new byte
          if (st_ff.wstrb_ff[0]) begin
            // 8-bit frames send a stop bit in the ninth slot, never the ninth-bit field
            nxt_st.tx_shift_ff = {1'b1,
                    st_ff.control_ff[uart_pkg::CTL_TX9] | ~st_ff.control_ff[uart_pkg::CTL_FRAME_WIDTH],
                    st_ff.wdata_ff[7:0]};
            nxt_st.tx_count_ff = st_ff.control_ff[uart_pkg::CTL_FRAME_WIDTH] ? 4'ha : 4'h9;
            nxt_st.tx_state_ff = TX_SHIFT;
            nxt_st.tx_pin_ff = 1'b0;
          end
        end
        uart_pkg::ADDR_TIMER: begin
          if (st_ff.wstrb_ff[0]) begin
            nxt_st.reload_ff = st_ff.wdata_ff[7:0];
          end
          if (st_ff.wstrb_ff[1]) begin
            nxt_st.clk_sel_ff = st_ff.wdata_ff[10:8];
            nxt_st.timer_run_ff = st_ff.wdata_ff[15];
          end
        end
        uart_pkg::ADDR_IRQ_MASK: begin
          if (st_ff.wstrb_ff[0]) begin
            nxt_st.irq_mask_ff = st_ff.wdata_ff[1:0];
          end
        end
        uart_pkg::ADDR_IRQ_STATUS: ;
        default: nxt_st.bresp_ff = uart_pkg::RESP_SLVERR;
      endcase
    end
    if (st_ff.bvalid_ff && S_AXI_BREADY) begin
      nxt_st.bvalid_ff = 1'b0;
    end

    // axi read
    rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
    unique case ({S_AXI_ARADDR[7:2], 2'b00})
      uart_pkg::ADDR_CONTROL: rd_val = {24'h0, st_ff.control_ff};
      uart_pkg::ADDR_DATA: rd_val = {24'h0, st_ff.rx_buffer_ff};
      uart_pkg::ADDR_TIMER: rd_val = {16'h0, st_ff.timer_run_ff, 4'h0, st_ff.clk_sel_ff, st_ff.reload_ff};
      uart_pkg::ADDR_IRQ_STATUS: rd_val = {30'h0, st_ff.irq_status_ff};
      uart_pkg::ADDR_IRQ_MASK: rd_val = {30'h0, st_ff.irq_mask_ff};
      default: rd_resp = uart_pkg::RESP_SLVERR;
    endcase
    if (rd_go) begin
      nxt_st.rvalid_ff = 1'b1;
      nxt_st.rdata_ff = rd_val;
      nxt_st.rresp_ff = rd_resp;
      if ({S_AXI_ARADDR[7:2], 2'b00} == uart_pkg::ADDR_IRQ_STATUS) begin
        nxt_st.irq_status_ff = 2'b00;
      end
    end
    if (st_ff.rvalid_ff && S_AXI_RREADY) begin
      nxt_st.rvalid_ff = 1'b0;
    end

    // hardware sets win over any clear in the same cycle
    if (set_tdone) begin
      nxt_st.control_ff[uart_pkg::CTL_TDONE] = 1'b1;
      nxt_st.irq_status_ff[1] = 1'b1;
    end
    if (set_rdone) begin
      nxt_st.control_ff[uart_pkg::CTL_RDONE] = 1'b1;
      nxt_st.irq_status_ff[0] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_ff <= '0;
      st_ff.rx_sync_ff <= 2'b11;
      st_ff.rx_prev_ff <= 1'b1;
      st_ff.control_ff <= uart_pkg::CONTROL_RESET;
      st_ff.tx_pin_ff <= 1'b1;
      st_ff.tx_state_ff <= TX_IDLE;
      st_ff.rx_state_ff <= RX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- uart_port_monitor.sv ----
module uart_port_monitor (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic TX_PIN,
  input wire logic IRQ
);
  logic [2:0] recent_ff;
  logic wr_go;
  logic rd_go;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  assign wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  // irq may only drop shortly after a read or a write data handshake
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      recent_ff <= 3'h0;
    end else if (rd_go || (S_AXI_WVALID && S_AXI_WREADY)) begin
      recent_ff <= 3'h5;
    end else if (recent_ff != 3'h0) begin
      recent_ff <= recent_ff - 3'h1;
    end
  end
  b_timing_a: assert property (wr_go |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer late or early");
  b_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  w_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while answer pending");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while data pending");
  r_answer_a: assert property (rd_go |=> S_AXI_RVALID)
    else $error("read answer missing");
  rd_unmapped_a: assert property (rd_go && S_AXI_ARADDR[7:2] > uart_pkg::ADDR_IRQ_MASK[7:2]
    |=> S_AXI_RRESP == uart_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answer wrong");
  tx_start_a: assert property (wr_go && S_AXI_AWADDR == uart_pkg::ADDR_DATA && S_AXI_WSTRB[0]
    |-> ##[2:4] !TX_PIN)
    else $error("data write sent no start bit");
  irq_fall_a: assert property ($fell(IRQ) |-> recent_ff != 3'h0)
    else $error("interrupt dropped on its own");
  cover property (rd_go && S_AXI_ARADDR == uart_pkg::ADDR_DATA);
  cover property ($rose(IRQ));
  cover property ($fell(TX_PIN));
endmodule

bind uart_serial_port uart_port_monitor i_mon (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .TX_PIN(TX_PIN), .IRQ(IRQ)
);

// ---- uart_far_end.sv ----
module uart_far_end #(parameter int BIT_CYCLES = 32) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rx_line <= f[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask
  // start bit may be short, so lock to its end; bit 0 must be 1
  task automatic recv(input logic nine, output logic [7:0] d, output logic b9, output logic stop);
    while (tx_line) @(posedge clk);
    while (!tx_line) @(posedge clk);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      d[i] = tx_line;
      repeat (BIT_CYCLES) @(posedge clk);
    end
    b9 = tx_line;
    if (nine) repeat (BIT_CYCLES) @(posedge clk);
    stop = tx_line;
  endtask
endmodule

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0;
  logic [3:0] w_strb = 4'h0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, osc = 1'b0, pin = 1'b0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, rx_line, tx_line, irq;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data;
  int errors = 0;
  int checked = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    osc <= ~osc;
    pin <= ~pin;
  end
  uart_serial_port i_dut (
    .CORE_CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .RX_PIN(rx_line), .TX_PIN(tx_line), .EXT_OSC(osc),
    .TIMER_EXT_PIN(pin), .IRQ(irq)
  );
  uart_far_end #(.BIT_CYCLES(32)) i_far (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    aw_addr <= a;
    w_data <= d;
    w_strb <= 4'hf;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (!b_v);
    rsp = b_resp;
    b_r <= 1'b0;
    // one edge gap so a following call never reassigns bready in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    ar_addr <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy) ar_v <= 1'b0;
    end while (!r_v);
    d = r_data;
    rsp = r_resp;
    r_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, d, e);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rdk(uart_pkg::ADDR_CONTROL, 32'h40, "control reset");
    rdk(uart_pkg::ADDR_IRQ_MASK, 32'h0, "mask reset");
    rd(8'h20, d, r);
    chk("rd resp", {30'h0, r}, {30'h0, uart_pkg::RESP_SLVERR});
    chk("rd data", d, 32'h0);
    wr(8'h20, 32'hff, r);
    chk("wr resp", {30'h0, r}, {30'h0, uart_pkg::RESP_SLVERR});
  endtask
  task automatic t_tx;
    logic [7:0] rl[4] = '{8'hf0, 8'hfc, 8'hff, 8'hf8};
    logic [2:0] sel[4] = '{uart_pkg::CLKSEL_SYS, uart_pkg::CLKSEL_DIV4, uart_pkg::CLKSEL_EXT8, uart_pkg::CLKSEL_PIN};
    logic [7:0] tx[4] = '{8'ha5, 8'h33, 8'h81, 8'hf7};
    logic [7:0] d;
    logic b9, sp;
    logic [1:0] r;
    wr(uart_pkg::ADDR_IRQ_MASK, 32'h2, r);
    // every source and reload pair gives a 32 cycle bit
    for (int k = 0; k < 4; k++) begin
      wr(uart_pkg::ADDR_TIMER, {16'h0, 1'b1, 4'h0, sel[k], rl[k]}, r);
      fork
        wr(uart_pkg::ADDR_DATA, {24'h0, tx[k]}, r);
        i_far.recv(1'b0, d, b9, sp);
      join
      chk("tx byte", {24'h0, d}, {24'h0, tx[k]});
      chk("tx stop", {31'h0, sp}, 32'h1);
      chk("irq tx", {31'h0, irq}, 32'h1);
      rdk(uart_pkg::ADDR_IRQ_STATUS, 32'h2, "irq status");
      repeat (2) @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      rdk(uart_pkg::ADDR_CONTROL, 32'h42, "tx flag kept");
      wr(uart_pkg::ADDR_CONTROL, 32'h0, r);
    end
    wr(uart_pkg::ADDR_CONTROL, 32'h88, r);
    fork
      wr(uart_pkg::ADDR_DATA, 32'h55, r);
      i_far.recv(1'b1, d, b9, sp);
    join
    chk("tx ninth", {31'h0, b9}, 32'h1);
    rdk(uart_pkg::ADDR_IRQ_STATUS, 32'h2, "irq status 9");
  endtask
  task automatic t_rx;
    logic [7:0] c[5] = '{8'h30, 8'hb0, 8'hb0, 8'h80, 8'h90};
    logic [7:0] dd[5] = '{8'h11, 8'h5a, 8'h22, 8'h44, 8'h66};
    logic nn[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic nb[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    // a control write also rewrites the received ninth-bit field
    logic [7:0] ec[5] = '{8'h70, 8'hf5, 8'hf0, 8'hc0, 8'hd1};
    logic [7:0] ed[5] = '{8'hc3, 8'h5a, 8'h5a, 8'h5a, 8'h66};
    logic [1:0] r;
    wr(uart_pkg::ADDR_IRQ_MASK, 32'h1, r);
    wr(uart_pkg::ADDR_CONTROL, 32'h10, r);
    i_far.send(8'h3c, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk("irq rx", {31'h0, irq}, 32'h1);
    rdk(uart_pkg::ADDR_CONTROL, 32'h55, "rx control");
    fork
      i_far.send(8'hc3, 1'b0, 1'b0, 1'b1);
      begin
        rdk(uart_pkg::ADDR_DATA, 32'h3c, "rx first");
        wr(uart_pkg::ADDR_CONTROL, 32'h10, r);
      end
    join
    repeat (4) @(posedge clk);
    rdk(uart_pkg::ADDR_DATA, 32'hc3, "rx second");
    i_far.send(8'h99, 1'b0, 1'b0, 1'b1);
    rdk(uart_pkg::ADDR_DATA, 32'hc3, "rx kept");
    rdk(uart_pkg::ADDR_IRQ_STATUS, 32'h1, "rx status");
    for (int k = 0; k < 5; k++) begin
      wr(uart_pkg::ADDR_CONTROL, {24'h0, c[k]}, r);
      i_far.send(dd[k], nn[k], nb[k], 1'b0 | nn[k]);
      repeat (4) @(posedge clk);
      rdk(uart_pkg::ADDR_CONTROL, {24'h0, ec[k]}, "mode control");
      rdk(uart_pkg::ADDR_DATA, {24'h0, ed[k]}, "mode data");
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_tx;
    t_rx;
    end_sim;
  end
endmodule
